/* File: rtl/irq_power_defs.vh */
`ifndef IRQ_POWER_DEFS_VH
`define IRQ_POWER_DEFS_VH

// Special register addresses
`define ADDR_POWER_MODE   8'h87
`define ADDR_TIMER_IRQ    8'h88
`define ADDR_IRQ_ENABLE   8'ha8
`define ADDR_IRQ_PRIORITY 8'hb8
`define ADDR_EXTRA_EXT    8'hc0

// Reset values
`define RST_POWER_MODE    8'h30
`define RST_CLEARED       8'h00

// Power mode control fields
`define PWR_IDLE_BIT      0
`define PWR_DOWN_BIT      1
`define PWR_KEEP_BIT      4

// Timer/irq control fields (external sources)
`define TIC_TRIG0_BIT     0
`define TIC_FLAG0_BIT     1
`define TIC_TRIG1_BIT     2
`define TIC_FLAG1_BIT     3

// Enable register global enable
`define IEN_GLOBAL_BIT    7

// Extra external irq control fields
`define XC_TRIG2_BIT      0
`define XC_FLAG2_BIT      1
`define XC_EN2_BIT        2
`define XC_PRI2_BIT       3
`define XC_TRIG3_BIT      4
`define XC_FLAG3_BIT      5
`define XC_EN3_BIT        6
`define XC_PRI3_BIT       7

// Vector low bits, vector = {source, 3'b011}
`define VEC_LOW           3'h3

// Machine cycle timing: clocks per cycle, sample slot
`define MC_CLKS           4'hc
`define MC_LAST           4'hb
`define MC_SAMPLE_SLOT    4'h9
`define RST_HOLD_MC       2'h2

`endif

/* File: rtl/reset_filter.v */
`timescale 1ns/1ps
`default_nettype none
`include "irq_power_defs.vh"

module reset_filter (
    input  wire       clk,
    input  wire       nrst,
    input  wire       reset_pin,
    output reg        pin_reset_reg
);

    reg       sync1_reg;   // First synchroniser stage
    reg       sync2_reg;   // Second synchroniser stage
    reg [3:0] slot_reg;    // Position within machine cycle
    reg [1:0] high_reg;    // Consecutive high samples

    // Two-flop synchroniser for the pin
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= reset_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // Machine cycle slot counter
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slot_reg <= 4'h0;
        end else if (slot_reg == `MC_LAST) begin
            slot_reg <= 4'h0;
        end else begin
            slot_reg <= slot_reg + 4'h1;
        end
    end

    // Sample once per cycle, need two highs in a row
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            high_reg      <= 2'h0;
            pin_reset_reg <= 1'b0;
        end else if (slot_reg == `MC_SAMPLE_SLOT) begin
            if (!sync2_reg) begin
                // A low sample drops any glitch
                high_reg      <= 2'h0;
                pin_reset_reg <= 1'b0;
            end else if (high_reg == `RST_HOLD_MC - 2'h1) begin
                high_reg      <= `RST_HOLD_MC;
                pin_reset_reg <= 1'b1;
            end else if (high_reg != `RST_HOLD_MC) begin
                high_reg <= high_reg + 2'h1;
            end
        end
    end

endmodule
`default_nettype wire

/* File: rtl/irq_power_ctrl.v */
// Contract
// - Idle stops processor clock, peripherals keep running
// - Interrupt taken or reset ends idle
// - Power-down stops all clocks and oscillator
// - Leave power-down by reset or level ext0/1
// - Reset sampled per machine cycle, two cycles
// - Reset pin is deglitched
// - Reset clears registers, power keeps bit four
// - Extra control register at C0, bit access
// - Priority bit selects high level, ext2/3
// - Ext2/3 need own enable bit set
// - Trigger bit one edge, zero level
// - Edge sets flag, service clears it
// - Vectors 03H to 3BH by source
// - Same level polled in order 0 to 7
// - Enable bits gate each of eight sources
// - Port four pins also feed ext2/3
`timescale 1ns/1ps
`default_nettype none
`include "irq_power_defs.vh"

module irq_power_ctrl (
    input  wire       clk,
    input  wire       nrst,
    input  wire       reset_pin,
    input  wire       ext_request_zero_pin_n,
    input  wire       ext_request_one_pin_n,
    input  wire       ext_request_two_pin_n,
    input  wire       ext_request_three_pin_n,
    input  wire       p4_pin_two,
    input  wire       p4_pin_three,
    input  wire       p4_two_gpio,
    input  wire       p4_three_gpio,
    input  wire       timer0_flag,
    input  wire       timer1_flag,
    input  wire       serial_flag,
    input  wire       timer2_flag,
    input  wire [7:0] sfr_addr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_bit_addr,
    input  wire       sfr_bit_set,
    input  wire       sfr_bit_clr,
    input  wire       irq_ack,
    input  wire       irq_reti,
    output reg  [7:0] sfr_rdata_reg,
    output reg        sfr_hit_reg,
    output reg        irq_req_reg,
    output reg  [7:0] irq_vector_reg,
    output reg  [7:0] irq_served_reg,
    output reg        cpu_clk_en_reg,
    output reg        osc_enable_reg,
    output reg        core_reset_reg
);

    // Merge a byte or bit write into a register
    function [7:0] merge;
        input [7:0] old;
        input [7:0] base;
        input       bit_ok;
        reg   [7:0] mask;
        begin
            mask = 8'h01 << sfr_bit_addr[2:0];
            if (sfr_wr && sfr_addr == base) begin
                merge = sfr_wdata;
            end else if (bit_ok && sfr_bit_addr[7:3] == base[7:3]
                         && sfr_bit_set) begin
                merge = old | mask;
            end else if (bit_ok && sfr_bit_addr[7:3] == base[7:3]
                         && sfr_bit_clr) begin
                merge = old & ~mask;
            end else begin
                merge = old;
            end
        end
    endfunction

    // Lowest set index, fixed polling order
    function [2:0] first_idx;
        input [7:0] vec;
        integer     k;
        begin
            first_idx = 3'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (vec[k]) begin
                    first_idx = k[2:0];
                end
            end
        end
    endfunction

    wire       pin_reset;      // Filtered reset from pin
    reg  [7:0] pwr_reg;        // Power mode control
    reg  [7:0] tic_reg;        // Timer/irq control
    reg  [7:0] ien_reg;        // Enable mask
    reg  [7:0] ipr_reg;        // Priority select
    reg  [7:0] xc_reg;         // Extra ext irq control
    reg  [3:0] pin_s1_reg;     // Pin sync stage one
    reg  [3:0] pin_s2_reg;     // Pin sync stage two
    reg  [1:0] p4_s1_reg;      // Port pin sync stage one
    reg  [1:0] p4_s2_reg;      // Port pin sync stage two
    reg  [3:0] pin_old_reg;    // Previous combined level
    reg        act_hi_reg;     // High level routine active
    reg        act_lo_reg;     // Low level routine active
    reg  [2:0] cur_src_reg;    // Source being offered
    reg        cur_hi_reg;     // Level being offered

    reg  [7:0] pwr_w;          // Values after software write
    reg  [7:0] tic_w;
    reg  [7:0] ien_w;
    reg  [7:0] ipr_w;
    reg  [7:0] xc_w;
    reg  [3:0] pin_lvl;        // Combined active-low levels
    reg  [3:0] trig;           // Edge mode per ext source
    reg  [3:0] flag_sw;        // Flags after write
    reg  [3:0] srv_clr;        // Service clears per ext source
    reg  [3:0] flag_next;      // Next ext flag values
    reg  [7:0] pend;           // Enabled pending sources
    reg  [7:0] pri;            // Priority per source
    reg  [7:0] pend_hi;
    reg  [7:0] pend_lo;
    reg        take_hi;
    reg        take_lo;
    reg        req_next;
    reg  [2:0] src_next;
    reg        wake_pd;
    reg  [7:0] pwr_next;
    reg  [7:0] rd_next;
    reg        hit_next;
    integer    i;

    // Filtered, cycle-sampled reset pin
    reset_filter u_reset_filter (
        .clk           (clk),
        .nrst          (nrst),
        .reset_pin     (reset_pin),
        .pin_reset_reg (pin_reset)
    );

    // Two-flop synchronisers on request pins
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_reg <= 4'hf;
            pin_s2_reg <= 4'hf;
            p4_s1_reg  <= 2'h3;
            p4_s2_reg  <= 2'h3;
        end else begin
            pin_s1_reg <= {ext_request_three_pin_n,
                           ext_request_two_pin_n,
                           ext_request_one_pin_n,
                           ext_request_zero_pin_n};
            pin_s2_reg <= pin_s1_reg;
            p4_s1_reg  <= {p4_pin_two, p4_pin_three};
            p4_s2_reg  <= p4_s1_reg;
        end
    end

    // Software view, flags and arbitration
    always @* begin
        pwr_w = merge(pwr_reg, `ADDR_POWER_MODE, 1'b0);
        tic_w = merge(tic_reg, `ADDR_TIMER_IRQ, 1'b1);
        ien_w = merge(ien_reg, `ADDR_IRQ_ENABLE, 1'b1);
        ipr_w = merge(ipr_reg, `ADDR_IRQ_PRIORITY, 1'b1);
        xc_w  = merge(xc_reg, `ADDR_EXTRA_EXT, 1'b1);
        // Port pins in I/O mode share the ext2/ext3 request lines
        pin_lvl[0] = pin_s2_reg[0];
        pin_lvl[1] = pin_s2_reg[1];
        pin_lvl[2] = pin_s2_reg[2]
                   & (p4_s2_reg[0] | ~p4_three_gpio);
        pin_lvl[3] = pin_s2_reg[3]
                   & (p4_s2_reg[1] | ~p4_two_gpio);
        trig    = {xc_reg[`XC_TRIG3_BIT], xc_reg[`XC_TRIG2_BIT],
                   tic_reg[`TIC_TRIG1_BIT], tic_reg[`TIC_TRIG0_BIT]};
        flag_sw = {xc_w[`XC_FLAG3_BIT], xc_w[`XC_FLAG2_BIT],
                   tic_w[`TIC_FLAG1_BIT], tic_w[`TIC_FLAG0_BIT]};
        // Accepted service of an ext source
        srv_clr = 4'h0;
        if (irq_ack && irq_req_reg) begin
            srv_clr = {cur_src_reg == 3'h7, cur_src_reg == 3'h6,
                       cur_src_reg == 3'h2, cur_src_reg == 3'h0};
        end
        for (i = 0; i < 4; i = i + 1) begin
            if (trig[i]) begin
                // Falling edge wins over any clear
                flag_next[i] = (pin_old_reg[i] & ~pin_lvl[i])
                             | (flag_sw[i] & ~srv_clr[i]);
            end else begin
                flag_next[i] = ~pin_lvl[i];
            end
        end
        pend = {xc_reg[`XC_FLAG3_BIT], xc_reg[`XC_FLAG2_BIT],
                timer2_flag, serial_flag, timer1_flag,
                tic_reg[`TIC_FLAG1_BIT], timer0_flag,
                tic_reg[`TIC_FLAG0_BIT]}
             & {xc_reg[`XC_EN3_BIT], xc_reg[`XC_EN2_BIT],
                ien_reg[5:0]}
             & {8{ien_reg[`IEN_GLOBAL_BIT]}};
        pri  = {xc_reg[`XC_PRI3_BIT], xc_reg[`XC_PRI2_BIT],
                ipr_reg[5:0]};
        pend_hi = pend & pri;
        pend_lo = pend & ~pri;
        // Only a higher level may interrupt a running routine
        take_hi = (pend_hi != 8'h00) && !act_hi_reg;
        take_lo = (pend_lo != 8'h00) && !act_hi_reg
                  && !act_lo_reg;
        req_next = (take_hi || take_lo) && !irq_ack;
        src_next = take_hi ? first_idx(pend_hi) : first_idx(pend_lo);
        // Level-triggered ext0/ext1 may end power-down
        wake_pd = ien_reg[`IEN_GLOBAL_BIT]
                  && ((ien_reg[0] && !trig[0] && !pin_lvl[0])
                   || (ien_reg[2] && !trig[1] && !pin_lvl[1]));
        pwr_next = pwr_w;
        if (req_next) begin
            pwr_next[`PWR_IDLE_BIT] = 1'b0;
        end
        if (wake_pd) begin
            pwr_next[`PWR_DOWN_BIT] = 1'b0;
        end
        // Register read mux
        hit_next = 1'b1;
        case (sfr_addr)
            `ADDR_POWER_MODE: begin
                rd_next = pwr_reg;
            end
            `ADDR_TIMER_IRQ: begin
                rd_next = tic_reg;
            end
            `ADDR_IRQ_ENABLE: begin
                rd_next = ien_reg;
            end
            `ADDR_IRQ_PRIORITY: begin
                rd_next = ipr_reg;
            end
            `ADDR_EXTRA_EXT: begin
                rd_next = xc_reg;
            end
            default: begin
                rd_next  = 8'h00;
                hit_next = 1'b0;
            end
        endcase
    end

    // Register file, cleared again by pin reset
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_reg     <= `RST_POWER_MODE;
            tic_reg     <= `RST_CLEARED;
            ien_reg     <= `RST_CLEARED;
            ipr_reg     <= `RST_CLEARED;
            xc_reg      <= `RST_CLEARED;
            pin_old_reg <= 4'hf;
        end else if (pin_reset) begin
            // Power register keeps its bit four
            pwr_reg     <= pwr_reg & (8'h01 << `PWR_KEEP_BIT);
            tic_reg     <= `RST_CLEARED;
            ien_reg     <= `RST_CLEARED;
            ipr_reg     <= `RST_CLEARED;
            xc_reg      <= `RST_CLEARED;
            pin_old_reg <= 4'hf;
        end else begin
            pwr_reg     <= pwr_next;
            tic_reg     <= tic_w;
            tic_reg[`TIC_FLAG0_BIT] <= flag_next[0];
            tic_reg[`TIC_FLAG1_BIT] <= flag_next[1];
            ien_reg     <= ien_w;
            ipr_reg     <= ipr_w;
            xc_reg      <= xc_w;
            xc_reg[`XC_FLAG2_BIT]   <= flag_next[2];
            xc_reg[`XC_FLAG3_BIT]   <= flag_next[3];
            pin_old_reg <= pin_lvl;
        end
    end

    // Request offer, acceptance and nesting
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_req_reg    <= 1'b0;
            irq_vector_reg <= 8'h00;
            irq_served_reg <= 8'h00;
            cur_src_reg    <= 3'h0;
            cur_hi_reg     <= 1'b0;
            act_hi_reg     <= 1'b0;
            act_lo_reg     <= 1'b0;
        end else if (pin_reset) begin
            irq_req_reg    <= 1'b0;
            irq_vector_reg <= 8'h00;
            irq_served_reg <= 8'h00;
            cur_src_reg    <= 3'h0;
            cur_hi_reg     <= 1'b0;
            act_hi_reg     <= 1'b0;
            act_lo_reg     <= 1'b0;
        end else begin
            irq_req_reg    <= req_next;
            irq_served_reg <= 8'h00;
            if (req_next) begin
                cur_src_reg    <= src_next;
                cur_hi_reg     <= take_hi;
                irq_vector_reg <= {2'b00, src_next, `VEC_LOW};
            end
            if (irq_ack && irq_req_reg) begin
                // Pulse tells the owning block its flag was served
                irq_served_reg <= 8'h01 << cur_src_reg;
                if (cur_hi_reg) begin
                    act_hi_reg <= 1'b1;
                end else begin
                    act_lo_reg <= 1'b1;
                end
            end else if (irq_reti) begin
                // Return closes the innermost level
                if (act_hi_reg) begin
                    act_hi_reg <= 1'b0;
                end else begin
                    act_lo_reg <= 1'b0;
                end
            end
        end
    end

    // Clock gating, read data and core reset
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_clk_en_reg <= 1'b1;
            osc_enable_reg <= 1'b1;
            core_reset_reg <= 1'b1;
            sfr_rdata_reg  <= 8'h00;
            sfr_hit_reg    <= 1'b0;
        end else begin
            core_reset_reg <= pin_reset;
            sfr_rdata_reg  <= rd_next;
            sfr_hit_reg    <= hit_next;
            if (pin_reset) begin
                cpu_clk_en_reg <= 1'b1;
                osc_enable_reg <= 1'b1;
            end else begin
                // Idle or power-down stops the processor clock
                cpu_clk_en_reg <= !pwr_next[`PWR_IDLE_BIT]
                               && !pwr_next[`PWR_DOWN_BIT];
                // Power-down also stops the oscillator
                osc_enable_reg <= !pwr_next[`PWR_DOWN_BIT];
            end
        end
    end

endmodule
`default_nettype wire

/* File: dv/irq_power_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_power_ctrl_asserts (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic       sfr_bit_set,
    input wire logic       sfr_bit_clr,
    input wire logic       irq_ack,
    input wire logic [7:0] sfr_rdata_reg,
    input wire logic       sfr_hit_reg,
    input wire logic       irq_req_reg,
    input wire logic [7:0] irq_vector_reg,
    input wire logic [7:0] irq_served_reg,
    input wire logic       cpu_clk_en_reg,
    input wire logic       osc_enable_reg
);
    // One of the five mapped registers
    wire mapped = (sfr_addr == 8'h87) || (sfr_addr == 8'h88) ||
                  (sfr_addr == 8'ha8) || (sfr_addr == 8'hb8) ||
                  (sfr_addr == 8'hc0);
    // Offered request accepted by the core
    wire take = irq_req_reg && irq_ack;
    // No register access this cycle
    wire quiet = !sfr_wr && !sfr_bit_set && !sfr_bit_clr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_req_drop: assert property (take |=> !irq_req_reg)
        else $error("request kept after acceptance");
    a_vec_form: assert property (irq_req_reg |->
        irq_vector_reg[7:6] == 2'h0 && irq_vector_reg[2:0] == 3'h3)
        else $error("vector outside slots");
    a_served_src: assert property (take |=>
        irq_served_reg == (8'h01 << $past(irq_vector_reg[5:3])))
        else $error("served source differs from vector");
    a_no_spurious: assert property (
        !take |=> irq_served_reg == 8'h00)
        else $error("served pulse without acceptance");
    a_hit_map: assert property (
        1'b1 |=> sfr_hit_reg == $past(mapped))
        else $error("hit flag wrong");
    a_unmapped_zero: assert property (
        !mapped |=> sfr_rdata_reg == 8'h00)
        else $error("unmapped read not zero");
    a_write_back: assert property (
        sfr_wr && sfr_addr == 8'hc0 ##1 quiet && sfr_addr == 8'hc0
        |=> (sfr_rdata_reg & 8'hdd) == ($past(sfr_wdata, 2) & 8'hdd))
        else $error("written control value not read back");
    a_osc_clk: assert property (
        !osc_enable_reg |-> !cpu_clk_en_reg)
        else $error("core clock runs without oscillator");
    a_idle_entry: assert property (
        sfr_wr && sfr_addr == 8'h87 && sfr_wdata == 8'h01
        ##1 !irq_req_reg |-> !cpu_clk_en_reg)
        else $error("idle did not stop core clock");
    a_idle_wake: assert property (
        $rose(irq_req_reg) && !cpu_clk_en_reg && osc_enable_reg
        |-> ##[1:2] cpu_clk_en_reg)
        else $error("request did not end idle");
    a_pd_entry: assert property (
        sfr_wr && sfr_addr == 8'h87 && sfr_wdata == 8'h02
        |=> ##[0:1] !osc_enable_reg)
        else $error("power-down kept oscillator");

    c_take: cover property (take);
    c_pd: cover property (!osc_enable_reg);
    c_idle: cover property ($fell(cpu_clk_en_reg) && osc_enable_reg);
    c_last: cover property (irq_served_reg == 8'h80);
endmodule

bind irq_power_ctrl irq_power_ctrl_asserts u_chk (
    .clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_bit_set(sfr_bit_set), .sfr_bit_clr(sfr_bit_clr),
    .irq_ack(irq_ack), .sfr_rdata_reg(sfr_rdata_reg),
    .sfr_hit_reg(sfr_hit_reg), .irq_req_reg(irq_req_reg),
    .irq_vector_reg(irq_vector_reg), .irq_served_reg(irq_served_reg),
    .cpu_clk_en_reg(cpu_clk_en_reg), .osc_enable_reg(osc_enable_reg));
`default_nettype wire

/* File: dv/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model #(
    parameter int RET_DLY = 12   // Cycles a routine runs
) (
    input wire logic  clk,
    input wire logic  nrst,
    input wire logic  ack_en,
    input wire logic  irq_req_reg,
    input wire logic  cpu_clk_en_reg,
    output var logic  irq_ack,
    output var logic  irq_reti
);
    logic [1:0] depth;   // Open routines
    logic [4:0] tmr;     // Cycles left in routine

    // Accept offers while running, return routines innermost first
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_ack <= 1'b0;
            irq_reti <= 1'b0;
            depth <= 2'h0;
            tmr <= 5'h00;
        end else begin
            // Stopped core cannot accept
            irq_ack <= ack_en && irq_req_reg && cpu_clk_en_reg && !irq_ack;
            irq_reti <= 1'b0;
            if (irq_ack) begin
                depth <= depth + 2'h1;
                tmr <= 5'(RET_DLY);
            end else if (tmr != 5'h00) begin
                tmr <= tmr - 5'h01;
            end else if (depth != 2'h0) begin
                // Nested return order
                irq_reti <= 1'b1;
                depth <= depth - 2'h1;
                tmr <= 5'(RET_DLY);
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/interrupt_power_reset_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module interrupt_power_reset_ctrl_tb_top;
    logic       clk, nrst, reset_pin, ack_en, wr, bset, bclr, p42, p43;
    logic       ack, reti, req, clk_en, osc, core_rst, hit, g, gp;
    logic [7:0] src_req, addr, wdata, baddr, rdata, vec, served, vec_seen;
    int         error_cnt, total_checks, reti_cnt, r0;

    irq_power_ctrl u_dut (
        .clk(clk), .nrst(nrst), .reset_pin(reset_pin),
        .ext_request_zero_pin_n(~src_req[0]),
        .ext_request_one_pin_n(~src_req[2]),
        .ext_request_two_pin_n(~src_req[6]),
        .ext_request_three_pin_n(~src_req[7]),
        .p4_pin_two(p42), .p4_pin_three(p43),
        .p4_two_gpio(gp), .p4_three_gpio(gp),
        .timer0_flag(src_req[1]), .timer1_flag(src_req[3]),
        .serial_flag(src_req[4]), .timer2_flag(src_req[5]),
        .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr),
        .sfr_bit_addr(baddr), .sfr_bit_set(bset), .sfr_bit_clr(bclr),
        .irq_ack(ack), .irq_reti(reti), .sfr_rdata_reg(rdata),
        .sfr_hit_reg(hit), .irq_req_reg(req), .irq_vector_reg(vec),
        .irq_served_reg(served), .cpu_clk_en_reg(clk_en),
        .osc_enable_reg(osc), .core_reset_reg(core_rst));

    core_model u_core (.clk(clk), .nrst(nrst), .ack_en(ack_en),
        .irq_req_reg(req), .cpu_clk_en_reg(clk_en),
        .irq_ack(ack), .irq_reti(reti));

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Vector at acceptance and routine returns recorded
    always @(posedge clk) begin
        if (ack && req)
            vec_seen <= vec;
        if (reti)
            reti_cnt <= reti_cnt + 1;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s exp %h got %h", nm, exp, got);
            error_cnt++;
        end
    endtask

    task automatic wr_b(input logic [7:0] a, d);
        @(posedge clk) addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
    endtask

    task automatic rd_b(input logic [7:0] a, exp);
        @(posedge clk) addr <= a;
        repeat (2) @(posedge clk);
        #1 chk($sformatf("reg %h", a), exp, rdata);
    endtask

    task automatic bit_op(input logic [7:0] ba, input logic s);
        @(posedge clk) baddr <= ba;
        bset <= s;
        bclr <= !s;
        @(posedge clk) bset <= 1'b0;
        bclr <= 1'b0;
    endtask

    // Bounded wait for a served pulse, then source and vector
    task automatic wait_srv(input int idx, lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            #1;
            if (served !== 8'h00)
                break;
        end
        if (n == lim) begin
            $display("wrong value served %0d exp pulse got none", idx);
            error_cnt++;
            wrap_up();
        end
        chk("served", 8'h01 << idx, served);
        chk("vector", {2'b00, 3'(idx), 3'b011}, vec_seen);
        // Served source drops its request, as its owner would
        @(posedge clk) src_req <= src_req & ~(8'h01 << idx);
        #1;
    endtask

    initial begin
        {nrst, reset_pin, ack_en, wr, bset, bclr} = 6'h00;
        {src_req, addr, wdata, baddr} = 32'h0;
        {p42, p43, gp} = 3'b111;
        {error_cnt, total_checks} = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd_b(8'h87, 8'h30);
        rd_b(8'h88, 8'h00);
        rd_b(8'ha8, 8'h00);
        rd_b(8'hb8, 8'h00);
        rd_b(8'hc0, 8'h00);
        wr_b(8'h90, 8'hff);
        rd_b(8'h90, 8'h00);
        chk("hit", 8'h00, hit);
        wr_b(8'hc0, 8'h44);
        rd_b(8'hc0, 8'h44);
        bit_op(8'hc7, 1'b1);
        rd_b(8'hc0, 8'hc4);
        bit_op(8'hc2, 1'b0);
        rd_b(8'hc0, 8'hc0);
        $display("test registers done");
        wr_b(8'ha8, 8'hbf);
        wr_b(8'hc0, 8'h44);
        @(posedge clk) src_req <= 8'hff;
        repeat (6) @(posedge clk);
        ack_en <= 1'b1;
        for (int i = 0; i < 8; i++)
            wait_srv(i, 40);
        $display("test polling done");
        wr_b(8'hc0, 8'h04);
        // Pin in strobe mode must not reach the request line
        @(posedge clk) p43 <= 1'b0;
        gp <= 1'b0;
        repeat (6) @(posedge clk);
        rd_b(8'hc0, 8'h04);
        @(posedge clk) gp <= 1'b1;
        wait_srv(6, 40);
        @(posedge clk) p43 <= 1'b1;
        repeat (20) @(posedge clk) ack_en <= 1'b0;
        wr_b(8'hc0, 8'h05);
        @(posedge clk) src_req[6] <= 1'b1;
        repeat (3) @(posedge clk) src_req[6] <= 1'b0;
        repeat (6) @(posedge clk);
        rd_b(8'hc0, 8'h07);
        @(posedge clk) ack_en <= 1'b1;
        wait_srv(6, 20);
        rd_b(8'hc0, 8'h05);
        wr_b(8'hc0, 8'h00);
        @(posedge clk) src_req[7] <= 1'b1;
        repeat (4) @(posedge clk);
        rd_b(8'hc0, 8'h20);
        repeat (20) @(posedge clk);
        #1 chk("request", 8'h00, req);
        @(posedge clk) src_req[7] <= 1'b0;
        repeat (4) @(posedge clk);
        rd_b(8'hc0, 8'h00);
        @(posedge clk) src_req[7] <= 1'b1;
        bit_op(8'hc6, 1'b1);
        wait_srv(7, 20);
        $display("test external modes done");
        repeat (30) @(posedge clk);
        wr_b(8'hc0, 8'hc0);
        wr_b(8'ha8, 8'h8a);
        @(posedge clk) src_req[1] <= 1'b1;
        wait_srv(1, 20);
        r0 = reti_cnt;
        @(posedge clk) src_req[7] <= 1'b1;
        src_req[3] <= 1'b1;
        wait_srv(7, 8);
        wait_srv(3, 60);
        chk("returns", 8'(r0 + 2), 8'(reti_cnt));
        $display("test priority done");
        repeat (40) @(posedge clk);
        wr_b(8'ha8, 8'h82);
        wr_b(8'h87, 8'h01);
        #1 chk("core clock", 8'h00, clk_en);
        chk("oscillator", 8'h01, osc);
        @(posedge clk) src_req[1] <= 1'b1;
        wait_srv(1, 20);
        chk("core clock", 8'h01, clk_en);
        repeat (20) @(posedge clk);
        wr_b(8'h88, 8'h00);
        wr_b(8'ha8, 8'h81);
        wr_b(8'h87, 8'h02);
        repeat (2) @(posedge clk);
        #1 chk("oscillator", 8'h00, osc);
        chk("core clock", 8'h00, clk_en);
        @(posedge clk) src_req[0] <= 1'b1;
        wait_srv(0, 40);
        chk("oscillator", 8'h01, osc);
        $display("test power modes done");
        wr_b(8'h87, 8'h30);
        // Pulse shorter than one machine cycle must be ignored
        repeat (8) @(posedge clk) reset_pin <= 1'b1;
        @(posedge clk) reset_pin <= 1'b0;
        g = 1'b0;
        repeat (40) @(posedge clk) g = g | (core_rst !== 1'b0);
        chk("glitch reset", 8'h00, g);
        @(posedge clk) reset_pin <= 1'b1;
        repeat (40) @(posedge clk);
        #1 chk("core reset", 8'h01, core_rst);
        @(posedge clk) reset_pin <= 1'b0;
        repeat (30) @(posedge clk);
        #1 chk("core reset", 8'h00, core_rst);
        rd_b(8'h87, 8'h10);
        rd_b(8'ha8, 8'h00);
        $display("test reset pin done");
        wrap_up();
    end
endmodule
`default_nettype wire
